// File: hdl/csb_cmp_flags.sv
// Purpose: Flags of a compare with immediate
// Assumes: Pure combinational, operands from the same clock
// Notes:   Sign flag is left as it was
`default_nettype none
`include "csb_defs.svh"
module csb_cmp_flags (
    // Operands
    input  wire logic [7:0] dst_val,
    input  wire logic [7:0] imm_val,
    input  wire logic [7:0] flags_in,
    // Result
    output logic      [7:0] flags_out
);
    logic [7:0] diff;

    always_comb begin
        diff = dst_val - imm_val;
        flags_out = flags_in;
        // Only the five compare flags move
        flags_out[`CSB_FLAG_Z] = (diff == 8'h00);
        flags_out[`CSB_FLAG_N] = diff[7];
        flags_out[`CSB_FLAG_V] = (dst_val[7] & ~imm_val[7] & ~diff[7]) | (~dst_val[7] & imm_val[7] & diff[7]);
        flags_out[`CSB_FLAG_C] = (~dst_val[7] & imm_val[7]) | (imm_val[7] & diff[7]) | (diff[7] & ~dst_val[7]);
        flags_out[`CSB_FLAG_H] = (~dst_val[3] & imm_val[3]) | (imm_val[3] & diff[3]) | (diff[3] & ~dst_val[3]);
    end

endmodule : csb_cmp_flags
`default_nettype wire

// File: hdl/csb_defs.svh
// Purpose: Constants for the compare, skip and branch control block
// Assumes: 16-bit instruction words, word-addressed program counter
// Notes:   Offsets, field positions, encodings and step counts
//
// Behaviour
// - Compare-skip-equal: equal registers advance PC by 2 or 3; flags untouched.
// - Compare-immediate: subtract constant, keep no result, update Z N V C H only.
// - Skip-register-bit-clear: selected bit 0 skips next instruction; flags untouched.
// - Skip-I/O-bit-set: selected I/O bit 1 skips next instruction; flags untouched.
// - Branch-flag-set: selected status bit 1 loads PC plus offset plus 1.
// - Branch-flag-clear: selected status bit 0 loads PC plus offset plus 1.
// - Skip-register-bit-set: selected bit 1 skips next instruction; flags untouched.
// - Skip-I/O-bit-clear: selected I/O bit 0 skips next instruction; flags untouched.
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH

// Status register bit positions
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_H 5

// Instruction masks and patterns
`define CSB_MASK_CSE   16'hfc00
`define CSB_PAT_CSE    16'h1000
`define CSB_MASK_CMI   16'hf000
`define CSB_PAT_CMI    16'h3000
`define CSB_MASK_SBR   16'hfe08
`define CSB_PAT_RBC    16'hfc00
`define CSB_PAT_RBS    16'hfe00
`define CSB_MASK_SBI   16'hff00
`define CSB_PAT_IBC    16'h9900
`define CSB_PAT_IBS    16'h9b00
`define CSB_MASK_BRB   16'hfc00
`define CSB_PAT_BFS    16'hf000
`define CSB_PAT_BFC    16'hf400

// Field positions
`define CSB_BIT_LSB    0
`define CSB_OFS_MSB    9
`define CSB_OFS_LSB    3

// Program counter steps
`define CSB_STEP_SEQ   16'h0001
`define CSB_STEP_SKIP1 16'h0002
`define CSB_STEP_SKIP2 16'h0003

// Status register after reset
`define CSB_FLAGS_RST  8'h00

`endif

// File: hdl/csb_flow_ctrl.sv
// Purpose: Executes compare, skip and conditional branch instructions
// Assumes: Operands arrive with the instruction in the same clock cycle
// Notes:   Result follows one cycle after a taken request; done lasts one cycle with ce high and holds while ce is low, the rest is held until the next
`default_nettype none
`include "csb_defs.svh"
module csb_flow_ctrl (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // Instruction and operands
    input  wire logic              req_valid,
    input  wire csb_pkg::csb_req_s req,
    input  wire logic [7:0]        flags_in,
    // Program counter and status update
    output logic                   done,
    output logic                   handled,
    output logic                   pc_load,
    output logic [15:0]            pc_next,
    output logic                   flags_we,
    output logic [7:0]             flags_out
);

    function automatic csb_pkg::csb_op_e decode(input logic [15:0] w);
        if ((w & `CSB_MASK_CSE) == `CSB_PAT_CSE)
            return csb_pkg::CSB_OP_CSE;
        if ((w & `CSB_MASK_CMI) == `CSB_PAT_CMI)
            return csb_pkg::CSB_OP_CMI;
        if ((w & `CSB_MASK_SBR) == `CSB_PAT_RBC)
            return csb_pkg::CSB_OP_RBC;
        if ((w & `CSB_MASK_SBR) == `CSB_PAT_RBS)
            return csb_pkg::CSB_OP_RBS;
        if ((w & `CSB_MASK_SBI) == `CSB_PAT_IBC)
            return csb_pkg::CSB_OP_IBC;
        if ((w & `CSB_MASK_SBI) == `CSB_PAT_IBS)
            return csb_pkg::CSB_OP_IBS;
        if ((w & `CSB_MASK_BRB) == `CSB_PAT_BFS)
            return csb_pkg::CSB_OP_BFS;
        if ((w & `CSB_MASK_BRB) == `CSB_PAT_BFC)
            return csb_pkg::CSB_OP_BFC;
        return csb_pkg::CSB_OP_NONE;
    endfunction : decode

    // Length of the following instruction picks the step
    function automatic logic [15:0] skip_step(input logic two_word);
        return two_word ? `CSB_STEP_SKIP2 : `CSB_STEP_SKIP1;
    endfunction : skip_step

    csb_pkg::csb_state_s state;
    csb_pkg::csb_state_s next_state;
    csb_pkg::csb_op_e    op;
    logic [7:0]          cmp_flg;
    logic [7:0]          imm_val;
    logic [2:0]          bit_sel;
    logic [15:0]         ofs;
    logic [15:0]         seq_pc;
    logic [15:0]         skip_pc;
    logic [15:0]         branch_pc;

    assign op        = decode(req.word);
    assign imm_val   = {req.word[11:8], req.word[3:0]};
    assign bit_sel   = req.word[`CSB_BIT_LSB +: 3];
    assign ofs       = {{9{req.word[`CSB_OFS_MSB]}}, req.word[`CSB_OFS_MSB:`CSB_OFS_LSB]};
    assign seq_pc    = req.pc + `CSB_STEP_SEQ;
    assign skip_pc   = req.pc + skip_step(req.next_two_word);
    assign branch_pc = req.pc + ofs + `CSB_STEP_SEQ;

    csb_cmp_flags u_cmp (
        .dst_val  (req.dst_val),
        .imm_val  (imm_val),
        .flags_in  (flags_in),
        .flags_out (cmp_flg)
    );

    always_comb begin
        next_state = state;
        next_state.res.done = 1'b0;
        if (req_valid) begin
            next_state.res.done    = 1'b1;
            next_state.handled     = (op != csb_pkg::CSB_OP_NONE);
            next_state.res.pc_load = 1'b1;
            next_state.res.pc_next = seq_pc;
            next_state.res.flags_we = 1'b0;
            next_state.res.flags    = flags_in;
            // Skips and branches never touch the flags
            unique case (op)
                csb_pkg::CSB_OP_CSE: begin
                    if (req.dst_val == req.src_val)
                        next_state.res.pc_next = skip_pc;
                end
                csb_pkg::CSB_OP_CMI: begin
                    next_state.res.flags_we = 1'b1;
                    next_state.res.flags    = cmp_flg;
                end
                csb_pkg::CSB_OP_RBC: begin
                    if (!req.src_val[bit_sel])
                        next_state.res.pc_next = skip_pc;
                end
                csb_pkg::CSB_OP_RBS: begin
                    if (req.src_val[bit_sel])
                        next_state.res.pc_next = skip_pc;
                end
                csb_pkg::CSB_OP_IBC: begin
                    if (!req.io_val[bit_sel])
                        next_state.res.pc_next = skip_pc;
                end
                csb_pkg::CSB_OP_IBS: begin
                    if (req.io_val[bit_sel])
                        next_state.res.pc_next = skip_pc;
                end
                csb_pkg::CSB_OP_BFS: begin
                    if (flags_in[bit_sel])
                        next_state.res.pc_next = branch_pc;
                end
                csb_pkg::CSB_OP_BFC: begin
                    if (!flags_in[bit_sel])
                        next_state.res.pc_next = branch_pc;
                end
                // Foreign words are left to other units
                csb_pkg::CSB_OP_NONE: begin
                    next_state.res.pc_load = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state.res.done    <= 1'b0;
            state.res.pc_load <= 1'b0;
            state.res.pc_next <= 16'h0000;
            state.res.flags_we <= 1'b0;
            state.res.flags    <= `CSB_FLAGS_RST;
            state.handled     <= 1'b0;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign done     = state.res.done;
    assign handled  = state.handled;
    assign pc_load  = state.res.pc_load;
    assign pc_next  = state.res.pc_next;
    assign flags_we  = state.res.flags_we;
    assign flags_out = state.res.flags;

    // Checks

    a_skip_equal_pc: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op == csb_pkg::CSB_OP_CSE && req.dst_val == req.src_val)
        |=> pc_load && !flags_we && pc_next == $past(req.pc) + ($past(req.next_two_word) ? 16'h0003 : 16'h0002))
        else $error("Equal compare did not skip");

    a_cmp_imm_flags: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op == csb_pkg::CSB_OP_CMI)
        |=> flags_we && flags_out[`CSB_FLAG_Z] == ($past(req.dst_val) == $past(imm_val))
            && flags_out[7:6] == $past(flags_in[7:6]) && flags_out[4] == $past(flags_in[4])
            && pc_next == $past(req.pc) + 16'h0001)
        else $error("Compare immediate flags wrong");

    a_reg_clr_skip: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op == csb_pkg::CSB_OP_RBC)
        |=> !flags_we && (pc_next - $past(req.pc) == 16'h0001) == $past(req.src_val[bit_sel]))
        else $error("Register bit clear skip wrong");

    a_io_set_skip: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op == csb_pkg::CSB_OP_IBS)
        |=> !flags_we && (pc_next - $past(req.pc) != 16'h0001) == $past(req.io_val[bit_sel]))
        else $error("I/O bit set skip wrong");

    a_branch_set_pc: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op == csb_pkg::CSB_OP_BFS && flags_in[bit_sel])
        |=> pc_load && pc_next == $past(req.pc) + $past(ofs) + 16'h0001)
        else $error("Branch on set flag missed");

    a_branch_set_seq: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op == csb_pkg::CSB_OP_BFS && !flags_in[bit_sel])
        |=> pc_load && !flags_we && pc_next == $past(req.pc) + 16'h0001)
        else $error("Branch on clear flag taken");

    a_branch_clr_pc: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op == csb_pkg::CSB_OP_BFC)
        ##1 ce [*2]
        |-> $past(pc_next, 1) == $past(req.pc, 2) + ($past(flags_in[bit_sel], 2) ? 16'h0001 : $past(ofs, 2) + 16'h0001))
        else $error("Branch on clear flag wrong");

    a_reg_set_skip: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op == csb_pkg::CSB_OP_RBS)
        |=> !flags_we && (pc_next - $past(req.pc) != 16'h0001) == $past(req.src_val[bit_sel]))
        else $error("Register bit set skip wrong");

    a_io_clr_skip: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op == csb_pkg::CSB_OP_IBC && !req.io_val[bit_sel] && req.next_two_word)
        |=> pc_next == $past(req.pc) + 16'h0003 && done)
        else $error("Two-word skip step wrong");

    a_done_pulse_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (!ce) |=> $stable(pc_next) && $stable(done))
        else $error("State moved with clock enable low");

    // The core loads from here for every word that belongs to us
    a_own_word_load: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op != csb_pkg::CSB_OP_NONE)
        |=> done && handled && pc_load)
        else $error("Own word not loaded");

    // Foreign words must leave the program counter to other units
    a_foreign_no_load: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op == csb_pkg::CSB_OP_NONE)
        |=> done && !handled && !pc_load && !flags_we)
        else $error("Foreign word acted on");

    a_flags_kept: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && req_valid && op != csb_pkg::CSB_OP_CMI)
        |=> !flags_we)
        else $error("Flags written outside compare");

    a_idle_no_done: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && !req_valid)
        |=> !done)
        else $error("Done without request");

endmodule : csb_flow_ctrl
`default_nettype wire

// File: hdl/csb_pkg.sv
// Purpose: Types for the compare, skip and branch control block
// Assumes: Constants come from csb_defs.svh
// Notes:   Carriers are packed structs
`default_nettype none
package csb_pkg;

    typedef enum logic [3:0] {
        CSB_OP_NONE,
        CSB_OP_CSE,
        CSB_OP_CMI,
        CSB_OP_RBC,
        CSB_OP_RBS,
        CSB_OP_IBC,
        CSB_OP_IBS,
        CSB_OP_BFS,
        CSB_OP_BFC
    } csb_op_e;

    // One instruction offered for execution
    typedef struct packed {
        logic [15:0] word;
        logic [15:0] pc;
        logic [7:0]  dst_val;
        logic [7:0]  src_val;
        logic [7:0]  io_val;
        logic        next_two_word;
    } csb_req_s;

    // Program counter and flag update
    typedef struct packed {
        logic        done;
        logic        pc_load;
        logic [15:0] pc_next;
        logic        flags_we;
        logic [7:0]  flags;
    } csb_res_s;

    typedef struct packed {
        csb_res_s res;
        logic     handled;
    } csb_state_s;

endpackage : csb_pkg
`default_nettype wire

// File: verif/csb_flow_ctrl_bench.sv
// Purpose: Self-checking bench for csb_flow_ctrl
// Assumes: Encodings and steps as in csb_defs.svh
// Notes:   Requests run back to back; inputs move on falling edges
`default_nettype none
module compare_skip_branch_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic              mclk;
    logic              rst_n;
    logic              ce;
    logic              req_valid;
    csb_pkg::csb_req_s req;
    logic [7:0]        flags_in;
    logic              done;
    logic              handled;
    logic              pc_load;
    logic [15:0]       pc_next;
    logic              flags_we;
    logic [7:0]        flags_out;
    int                error_cnt;
    int                cmp_count;

    csb_flow_ctrl dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid), .req(req),
        .flags_in(flags_in), .done(done), .handled(handled), .pc_load(pc_load), .pc_next(pc_next),
        .flags_we(flags_we), .flags_out(flags_out));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic wrap_up;
        $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Own flag model; the sign flag is copied, as the designer chose
    function automatic logic [7:0] imm_flags(input logic [7:0] d, input logic [7:0] k, input logic [7:0] sr);
        logic [7:0] r;
        logic [7:0] f;
        r = d - k;
        f = sr;
        f[0] = k > d;
        f[1] = r == 8'h00;
        f[2] = r[7];
        f[3] = (d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]);
        f[5] = (~d[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~d[3]);
        return f;
    endfunction : imm_flags

    // One request; fl is {handled, pc_load, flags_we}
    task automatic run(input logic [15:0] w, input logic [15:0] pc, input logic [7:0] d, input logic [7:0] s,
                       input logic [7:0] io, input logic two, input logic [7:0] sr, input logic [2:0] fl,
                       input logic [15:0] pcn);
        req_valid = 1'b1;
        req       = '{w, pc, d, s, io, two};
        flags_in  = sr;
        @(negedge mclk);
        check({12'h000, done, handled, pc_load, flags_we}, {13'h0001, fl});
        if (fl[1]) begin
            check(pc_next, pcn);
        end
    endtask : run

    task automatic t_reset;
        rst_n     = 1'b0;
        req_valid = 1'b0;
        repeat (4) @(negedge mclk);
        check({4'h0, done, handled, pc_load, flags_we, flags_out}, 16'h0000);
        check(pc_next, 16'h0000);
        rst_n = 1'b1;
    endtask : t_reset

    task automatic t_cmp_skip;
        run(16'h1234, 16'h0010, 8'h5a, 8'h5a, 8'h00, 1'b0, 8'hff, 3'b110, 16'h0012); // equal
        run(16'h13ff, 16'hfffe, 8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 3'b110, 16'h0001); // long next
        run(16'h1000, 16'h0020, 8'h5a, 8'h5b, 8'h00, 1'b1, 8'h00, 3'b110, 16'h0021); // unequal
    endtask : t_cmp_skip

    task automatic t_cmp_imm;
        logic [7:0] dv [4] = '{8'h00, 8'h10, 8'h80, 8'h01};
        logic [7:0] kv [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
        logic [7:0] sr;
        for (int i = 0; i < 4; i++) begin
            sr = i[0] ? 8'hd0 : 8'h2f;
            run({4'h3, kv[i][7:4], 4'h7, kv[i][3:0]}, 16'h0040, dv[i], 8'ha5, 8'h00, 1'b1, sr, 3'b111,
                16'h0041);
            check({8'h00, flags_out}, {8'h00, imm_flags(dv[i], kv[i], sr)}); // flags
        end
    endtask : t_cmp_imm

    // Each bit position, both outcomes, long skip on odd positions only
    task automatic t_bits;
        logic [7:0]  m;
        logic [15:0] bw;
        logic [15:0] sk;
        for (int i = 0; i < 8; i++) begin
            m  = 8'h01 << i;
            bw = 16'(i);
            sk = i[0] ? 16'h0103 : 16'h0102;
            run(16'hfe00 | bw, 16'h0100, 8'h00, m, ~m, i[0], 8'h00, 3'b110, sk); // set
            run(16'hfe00 | bw, 16'h0100, 8'h00, ~m, m, i[0], 8'h00, 3'b110, 16'h0101);
            run(16'hfc00 | bw, 16'h0100, 8'h00, ~m, m, i[0], 8'h00, 3'b110, sk); // clear
            run(16'hfc00 | bw, 16'h0100, 8'h00, m, ~m, i[0], 8'h00, 3'b110, 16'h0101);
            run(16'h9b00 | bw, 16'h0100, 8'h00, ~m, m, i[0], 8'h00, 3'b110, sk); // set
            run(16'h9b00 | bw, 16'h0100, 8'h00, m, ~m, i[0], 8'h00, 3'b110, 16'h0101);
            run(16'h9900 | bw, 16'h0100, 8'h00, m, ~m, i[0], 8'h00, 3'b110, sk); // clear
            run(16'h9900 | bw, 16'h0100, 8'h00, ~m, m, i[0], 8'h00, 3'b110, 16'h0101);
        end
    endtask : t_bits

    // Offsets at both ends of the signed range
    task automatic t_branch;
        logic [7:0]  m;
        logic [15:0] bw;
        for (int i = 0; i < 8; i++) begin
            m  = 8'h01 << i;
            bw = 16'(i);
            run(16'hf200 | bw, 16'h0080, 8'h00, 8'h00, 8'h00, 1'b0, m, 3'b110, 16'h0041);
            run(16'hf200 | bw, 16'h0080, 8'h00, 8'h00, 8'h00, 1'b0, ~m, 3'b110, 16'h0081);
            run(16'hf5f8 | bw, 16'h0080, 8'h00, 8'h00, 8'h00, 1'b0, ~m, 3'b110, 16'h00c0);
            run(16'hf5f8 | bw, 16'h0080, 8'h00, 8'h00, 8'h00, 1'b0, m, 3'b110, 16'h0081);
        end
    endtask : t_branch

    task automatic t_other;
        run(16'h0000, 16'h0300, 8'h00, 8'h00, 8'h00, 1'b0, 8'hff, 3'b000, 16'h0000);
        run(16'h2c00, 16'h0301, 8'h11, 8'h11, 8'h00, 1'b0, 8'hff, 3'b000, 16'h0000);
    endtask : t_other

    // Frozen while ce is low, then one pulse
    task automatic t_ce;
        ce        = 1'b0;
        req_valid = 1'b1;
        req       = '{16'hf008, 16'h0200, 8'h00, 8'h00, 8'h00, 1'b0};
        flags_in  = 8'h01;
        repeat (2) @(negedge mclk);
        check({done, handled, pc_load, pc_next[12:0]}, 16'h0000);
        ce = 1'b1;
        run(16'hf008, 16'h0200, 8'h00, 8'h00, 8'h00, 1'b0, 8'h01, 3'b110, 16'h0202);
        req_valid = 1'b0;
        @(negedge mclk);
        check({15'h0000, done}, 16'h0000);
        check(pc_next, 16'h0202);
    endtask : t_ce

    // Watchdog, well above the longest run
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        error_cnt = 0;
        cmp_count = 0;
        rst_n     = 1'b0;
        ce        = 1'b1;
        req_valid = 1'b0;
        req       = '0;
        flags_in  = 8'h00;
        @(negedge mclk);
        t_reset();
        t_cmp_skip();
        t_cmp_imm();
        t_bits();
        t_branch();
        t_other();
        t_reset();
        t_ce();
        wrap_up();
    end
endmodule : compare_skip_branch_control_bench
`default_nettype wire
